// ---- core/counter_array.sv ----
// Programmable counter array counter, timebase and interrupt tree
`timescale 1ns/1ps
`include "counter_array_defs.svh"
module counter_array
  import counter_array_pkg::*;
(
  input  wire logic       sys_clk,         // 20 MHz system clock
  input  wire logic       rst,             // Async reset, active high
  input  wire reg_req_t   req,             // Register bus request
  output logic      [7:0] rdata,           // Read data, cycle after read
  input  wire logic       ext_count_input, // External count pin
  input  wire logic       xosc_clk,        // External oscillator pin
  input  wire logic       lfosc_clk,       // Low-frequency oscillator pin
  input  wire logic       t0_overflow,     // Timer 0 overflow pulse
  input  wire logic       cpu_idle,        // Processor in idle mode
  input  wire logic       global_irq_en,   // Processor global enable
  input  wire logic       array_irq_en,    // Array-level enable
  input  wire logic [2:0] channel_event,   // Channel trigger pulses
  input  wire logic [2:0] channel_io_in,   // Channel pins, input side
  output logic      [2:0] channel_io_line, // Channel pin drive
  output logic      [2:0] channel_io_oe,   // Channel pin enables
  output logic      [2:0] channel_io_sync, // Synced channel pin levels
  output logic            irq,             // Combined interrupt request
  output logic            watchdog_mode    // Watchdog mode active
);
  ////////////////////////////////////////////////////////////////////
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0]  snap_r;
  logic [7:0]  mode_r;  // idle, wdt, 3'b0, timebase
  logic [1:0]  intermediate_overflow_flag_sel_r;
  logic [7:0]  flags_r; // cf, intermediate_overflow_flag, 3'b0, ccf[2:0]
  logic [4:0]  ien_r;   // ecf, intermediate_overflow_irq_en, eccf[2:0]
  logic [3:0]  div12_r, div4_r;
  logic [2:0]  ext_s_r, xo_s_r, lf_s_r, io_s_r, io_s2_r;
  logic [2:0]  xo_div_r, lf_div_r;
  logic        irq_r;

  // Register decode
  wire wr_low  = req.wr && req.addr == `ADDR_LOW;
  wire wr_high = req.wr && req.addr == `ADDR_HIGH;
  wire wr_mode = req.wr && req.addr == `ADDR_MODE;
  wire wr_ctrl = req.wr && req.addr == `ADDR_CTRL;
  wire wr_ien  = req.wr && req.addr == `ADDR_IEN;
  wire rd_low  = req.rd && req.addr == `ADDR_LOW;
  // Watchdog lock: counter writes ignored, mode writes ignored unless they clear the watchdog bit
  wire wdt_on  = mode_r[`BIT_WDT];
  wire wr_mode_ok = wr_mode && (!wdt_on || !req.wdata[`BIT_WDT]);

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; first stage read only by second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_s_r <= 3'h0;
      xo_s_r  <= 3'h0;
      lf_s_r  <= 3'h0;
      io_s_r  <= 3'h0;
      io_s2_r <= 3'h0;
    end else begin
      ext_s_r <= {ext_s_r[1:0], ext_count_input};
      xo_s_r  <= {xo_s_r[1:0], xosc_clk};
      lf_s_r  <= {lf_s_r[1:0], lfosc_clk};
      io_s_r  <= channel_io_in;
      io_s2_r <= io_s_r;
    end
  end
  // Edge detect on stages 2 and 3 only
  wire ext_fall = ext_s_r[2] && !ext_s_r[1];
  wire xo_rise  = !xo_s_r[2] && xo_s_r[1];
  wire lf_rise  = !lf_s_r[2] && lf_s_r[1];

  ////////////////////////////////////////////////////////////////////
  // Prescalers run freely so a timebase switch needs no restart
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div12_r  <= 4'h0;
      div4_r   <= 4'h0;
      xo_div_r <= 3'h0;
      lf_div_r <= 3'h0;
    end else begin
      div12_r  <= (div12_r == `DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      div4_r   <= (div4_r == `DIV4_LAST) ? 4'h0 : div4_r + 4'h1;
      xo_div_r <= xo_rise ? xo_div_r + 3'h1 : xo_div_r;
      lf_div_r <= lf_rise ? lf_div_r + 3'h1 : lf_div_r;
    end
  end

  wire tick12 = div12_r == `DIV12_LAST;
  wire tick4  = div4_r == `DIV4_LAST;
  wire tick_xo = xo_rise && xo_div_r == `DIV8_LAST;
  wire tick_lf = lf_rise && lf_div_r == `DIV8_LAST;
  logic tick;
  // Timebase selection, reserved code never ticks
  always_comb begin
    unique case (mode_r[2:0])
      `TB_DIV12:  tick = tick12;
      `TB_DIV4:   tick = tick4;
      `TB_T0OVF:  tick = t0_overflow;
      `TB_EXT:    tick = ext_fall;
      `TB_SYSCLK: tick = 1'b1;
      `TB_XOSC:   tick = tick_xo;
      `TB_LFOSC:  tick = tick_lf;
      default:    tick = 1'b0;
    endcase
  end

  wire run = tick && !(cpu_idle && mode_r[`BIT_IDLE]);
  wire wrap = run && cnt_r == `CNT_MAX;
  // Carry out of selected bit 7..10 into next
  wire [3:0] low_ones;
  for (genvar g = 0; g < 4; g++) begin : g_carry
    // All ones up to bit 7+g means the next tick carries out of it
    assign low_ones[g] = &cnt_r[`INTERMEDIATE_OVERFLOW_FLAG_BASE_BIT + g:0];
  end
  wire intermediate_overflow_flag_ev = run && low_ones[intermediate_overflow_flag_sel_r];

  ////////////////////////////////////////////////////////////////////
  // Counter; reads leave it alone, writes load a byte
  always_comb begin
    cnt_nxt = run ? cnt_r + 16'h0001 : cnt_r;
    if (wr_low && !wdt_on)
      cnt_nxt[7:0] = req.wdata;
    if (wr_high && !wdt_on)
      cnt_nxt[15:8] = req.wdata;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Snapshot high byte on low read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      snap_r <= 8'h00;
    end else if (rd_low) begin
      snap_r <= cnt_r[15:8];
    end
  end

  // Mode and control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r     <= `MODE_RESET;
      intermediate_overflow_flag_sel_r <= 2'h0;
      ien_r      <= 5'h00;
    end else begin
      if (wr_mode_ok)
        mode_r <= {req.wdata[7:6], 3'h0, req.wdata[2:0]};
      if (wr_ctrl && !wdt_on)
        intermediate_overflow_flag_sel_r <= req.wdata[1:0];
      if (wr_ien)
        ien_r <= req.wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flags: hardware sets, software writes; set wins
  wire [7:0] ev_set = {wrap, intermediate_overflow_flag_ev, 3'h0, channel_event};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_r <= 8'h00;
    end else if (wr_ctrl) begin
      flags_r <= {req.wdata[7:6], 3'h0, req.wdata[2:0]} | ev_set;
    end else begin
      flags_r <= flags_r | ev_set;
    end
  end

  wire [4:0] flag5 = {flags_r[`BIT_CF], flags_r[`BIT_INTERMEDIATE_OVERFLOW_FLAG], flags_r[2:0]};
  wire irq_nxt = global_irq_en && array_irq_en && |(flag5 & ien_r);

  // Read mux; high read returns the snapshot
  logic [7:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      `ADDR_LOW:  rd_mux = cnt_r[7:0];
      `ADDR_HIGH: rd_mux = snap_r;
      `ADDR_MODE: rd_mux = mode_r;
      `ADDR_CTRL: rd_mux = {flags_r[7:6], 4'h0, intermediate_overflow_flag_sel_r};
      `ADDR_IEN:  rd_mux = {3'h0, ien_r};
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_mux : 8'h00;
      irq_r <= irq_nxt;
    end
  end

  // Channel I/O lines idle until modules attach; pins synced
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_io_line <= 3'h0;
      channel_io_oe   <= 3'h0;
      channel_io_sync <= 3'h0;
      watchdog_mode   <= 1'b1;
    end else begin
      channel_io_line <= 3'h0;
      channel_io_oe   <= 3'h0;
      channel_io_sync <= io_s2_r;
      watchdog_mode   <= wdt_on;
    end
  end
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////
  a_wrap_sets_cf: assert property (@(posedge sys_clk) disable iff (rst)
    wrap |=> flags_r[`BIT_CF])
    else $error("overflow flag not set on wrap");
  a_cf_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    flags_r[`BIT_CF] && !wr_ctrl |=> flags_r[`BIT_CF])
    else $error("overflow flag cleared without write");
  a_snapshot_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd_low ##1 (req.rd && req.addr == `ADDR_HIGH) |=> rdata == $past(cnt_r[15:8], 2))
    else $error("high read missed snapshot");
  a_read_no_disturb: assert property (@(posedge sys_clk) disable iff (rst)
    req.rd && !req.wr |=> cnt_r == $past(cnt_r) + {15'h0, $past(run)})
    else $error("read disturbed counter");
  a_sysclk_count: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_SYSCLK && !cpu_idle && !req.wr |=> cnt_r == $past(cnt_r) + 16'h1)
    else $error("system clock timebase not counting");
  a_idle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_idle && mode_r[`BIT_IDLE] && !req.wr |=> $stable(cnt_r))
    else $error("counter moved while suspended");
  a_reserved_hold: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_RESERVED && !req.wr |=> $stable(cnt_r))
    else $error("reserved timebase counted");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !global_irq_en || !array_irq_en |=> !irq)
    else $error("interrupt without both enables");
  a_irq_or: assert property (@(posedge sys_clk) disable iff (rst)
    global_irq_en && array_irq_en && |(flag5 & ien_r) |=> irq)
    else $error("enabled flag gave no interrupt");
  a_ch_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    channel_event[0] |=> flags_r[0])
    else $error("channel flag not set");
  a_ext_fall: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_EXT && !cpu_idle && !req.wr && ext_fall |=> cnt_r != $past(cnt_r))
    else $error("input fall not counted");

  ////////////////////////////////////////////////////////////////////
  // Prescalers keep their periods whatever the timebase
  a_div12_period: assert property (@(posedge sys_clk) disable iff (rst)
    tick12 |-> ##`DIV12_RATE tick12)
    else $error("twelve-cycle prescaler lost its period");
  a_div12_gap: assert property (@(posedge sys_clk) disable iff (rst)
    tick12 |=> !tick12)
    else $error("twelve-cycle prescaler ticked twice");
  a_div4_period: assert property (@(posedge sys_clk) disable iff (rst)
    tick4 |-> ##`DIV4_RATE tick4)
    else $error("four-cycle prescaler lost its period");
  a_div4_gap: assert property (@(posedge sys_clk) disable iff (rst)
    tick4 |=> !tick4)
    else $error("four-cycle prescaler ticked twice");
  // Timebases only move the counter on their own tick
  a_slow_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !run && !req.wr |=> $stable(cnt_r))
    else $error("counter moved without a tick");
  a_t0_count: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_T0OVF && t0_overflow && !cpu_idle && !req.wr
      |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("timer overflow not counted");
  a_ext_no_fall: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_EXT && !ext_fall && !req.wr |=> $stable(cnt_r))
    else $error("input counted without a fall");
  a_xo_div8: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_XOSC && !tick_xo && !req.wr |=> $stable(cnt_r))
    else $error("external oscillator count off divide");
  a_lf_div8: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_LFOSC && !tick_lf && !req.wr |=> $stable(cnt_r))
    else $error("slow oscillator count off divide");
  a_xo_div_step: assert property (@(posedge sys_clk) disable iff (rst)
    xo_rise |=> xo_div_r == $past(xo_div_r) + 3'h1)
    else $error("external oscillator edge missed");
  a_lf_div_step: assert property (@(posedge sys_clk) disable iff (rst)
    lf_rise |=> lf_div_r == $past(lf_div_r) + 3'h1)
    else $error("slow oscillator edge missed");
  a_idle_run: assert property (@(posedge sys_clk) disable iff (rst)
    mode_r[2:0] == `TB_SYSCLK && cpu_idle && !mode_r[`BIT_IDLE] && !req.wr
      |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter stopped in idle without suspend");
  // Flags and the interrupt tree
  a_cf_no_spur: assert property (@(posedge sys_clk) disable iff (rst)
    !wrap && !wr_ctrl && !flags_r[`BIT_CF] |=> !flags_r[`BIT_CF])
    else $error("overflow flag set without a wrap");
  a_cf_sw_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_ctrl && !req.wdata[`BIT_CF] && !wrap |=> !flags_r[`BIT_CF])
    else $error("software clear of overflow flag lost");
  a_intermediate_overflow_flag_sets: assert property (@(posedge sys_clk) disable iff (rst)
    intermediate_overflow_flag_ev |=> flags_r[`BIT_INTERMEDIATE_OVERFLOW_FLAG])
    else $error("intermediate overflow flag not set");
  a_intermediate_overflow_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    flags_r[`BIT_INTERMEDIATE_OVERFLOW_FLAG] && !wr_ctrl |=> flags_r[`BIT_INTERMEDIATE_OVERFLOW_FLAG])
    else $error("intermediate flag dropped without write");
  a_irq_cf: assert property (@(posedge sys_clk) disable iff (rst)
    global_irq_en && array_irq_en && ien_r[`BIT_ECF] && flags_r[`BIT_CF] |=> irq)
    else $error("enabled overflow flag gave no interrupt");
  a_irq_intermediate_overflow_flag: assert property (@(posedge sys_clk) disable iff (rst)
    global_irq_en && array_irq_en && ien_r[`BIT_INTERMEDIATE_OVERFLOW_IRQ_EN] && flags_r[`BIT_INTERMEDIATE_OVERFLOW_FLAG] |=> irq)
    else $error("enabled intermediate flag gave no interrupt");
  a_irq_mask: assert property (@(posedge sys_clk) disable iff (rst)
    (flag5 & ien_r) == 5'h00 |=> !irq)
    else $error("interrupt with no enabled flag");
  // Snapshot, read port and watchdog lock
  a_snap_capture: assert property (@(posedge sys_clk) disable iff (rst)
    rd_low |=> snap_r == $past(cnt_r[15:8]))
    else $error("snapshot missed the high byte");
  a_snap_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_low |=> $stable(snap_r))
    else $error("snapshot changed without a low read");
  a_rdata_high: assert property (@(posedge sys_clk) disable iff (rst)
    req.rd && req.addr == `ADDR_HIGH |=> rdata == $past(snap_r))
    else $error("high read bypassed the snapshot");
  a_rdata_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !req.rd |=> rdata == 8'h00)
    else $error("read data outside a read cycle");
  a_wdt_mode_lock: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_on && wr_mode && req.wdata[`BIT_WDT] |=> $stable(mode_r))
    else $error("mode written while watchdog locked");
  a_wdt_cnt_lock: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_on && !run |=> $stable(cnt_r))
    else $error("counter written while watchdog locked");
  a_wdt_out: assert property (@(posedge sys_clk) disable iff (rst)
    watchdog_mode == $past(wdt_on))
    else $error("watchdog indicator out of step");
  a_io_sync: assert property (@(posedge sys_clk) disable iff (rst)
    channel_io_sync == $past(channel_io_in, 3))
    else $error("channel pin copy out of step");
  // Channel flags stay until software clears them
  for (genvar c = 0; c < 3; c++) begin : g_ch_chk
    a_ch_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      flags_r[`BIT_CCF_LO + c] && !wr_ctrl |=> flags_r[`BIT_CCF_LO + c])
      else $error("channel flag dropped without a write");
  end
endmodule // counter_array

// ---- core/counter_array_defs.svh ----
// Constants for the programmable counter array core
`ifndef COUNTER_ARRAY_DEFS_SVH
`define COUNTER_ARRAY_DEFS_SVH
`define ADDR_LOW      4'h0
`define ADDR_HIGH     4'h1
`define ADDR_MODE     4'h2
`define ADDR_CTRL     4'h3
`define ADDR_IEN      4'h4
`define DIV12_LAST    4'hb
`define DIV4_LAST     4'h3
`define DIV8_LAST     3'h7
`define TB_DIV12      3'h0
`define TB_DIV4       3'h1
`define TB_T0OVF      3'h2
`define TB_EXT        3'h3
`define TB_SYSCLK     3'h4
`define TB_XOSC       3'h5
`define TB_LFOSC      3'h6
`define MODE_RESET    8'h40
`define BIT_IDLE      7
`define BIT_WDT       6
`define BIT_CF        7
`define BIT_INTERMEDIATE_OVERFLOW_FLAG      6
`define BIT_CCF_LO    0
`define BIT_ECF       4
`define BIT_INTERMEDIATE_OVERFLOW_IRQ_EN      3
`define CNT_MAX       16'hffff
`define TB_RESERVED   3'h7
`define INTERMEDIATE_OVERFLOW_FLAG_BASE_BIT 7
`define DIV12_RATE    12
`define DIV4_RATE     4
`endif

// ---- core/counter_array_pkg.sv ----
// Types for the programmable counter array core
package counter_array_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  typedef struct packed {
    logic [1:0] intermediate_overflow_flag_sel; // 0..3 = bit 8..11
    logic [2:0] timebase;
  } mode_t;
endpackage

// ---- sim/tb.sv ----
// Self-checking bench for the counter array core
`timescale 1ns/1ps
`include "counter_array_defs.svh"
module tb;
  import counter_array_pkg::*;
  logic       sys_clk, rst, ext_count_input, xosc_clk, lfosc_clk, t0_overflow, cpu_idle;
  logic       global_irq_en, array_irq_en, irq, watchdog_mode;
  logic [2:0] channel_event, channel_io_in, channel_io_line, channel_io_oe, channel_io_sync;
  logic [7:0] rdata, a, b;
  reg_req_t   req;
  int         error_cnt, compares;

  counter_array DUT (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
    .ext_count_input(ext_count_input), .xosc_clk(xosc_clk), .lfosc_clk(lfosc_clk),
    .t0_overflow(t0_overflow), .cpu_idle(cpu_idle), .global_irq_en(global_irq_en),
    .array_irq_en(array_irq_en), .channel_event(channel_event),
    .channel_io_in(channel_io_in), .channel_io_line(channel_io_line),
    .channel_io_oe(channel_io_oe), .channel_io_sync(channel_io_sync), .irq(irq),
    .watchdog_mode(watchdog_mode));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Shared check, hex report on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bus cycles: one strobe cycle, data the cycle after a read
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [7:0] v);
    @(posedge sys_clk);
    req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Low then high read strobed back to back, as software pairs them
  task automatic rd_pair(output logic [7:0] lo, output logic [7:0] hi);
    @(posedge sys_clk);
    req <= '{addr: `ADDR_LOW, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.addr <= `ADDR_HIGH;
    #1 lo = rdata;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 hi = rdata;
  endtask

  // Count a source over a fixed window; kind 0 is 48 cycles of plain time
  task automatic cnt(input logic [7:0] md, input int kind, input int n, input logic [7:0] e);
    wr(`ADDR_MODE, md);
    rd(`ADDR_LOW, a);
    if (kind == 0) repeat (46) @(posedge sys_clk);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk);
      case (kind)
        1: t0_overflow <= 1'b1;
        2: ext_count_input <= 1'b0;
        3: xosc_clk <= 1'b1;
        default: lfosc_clk <= 1'b1;
      endcase
      @(posedge sys_clk);
      t0_overflow <= 1'b0; // Overflow is a one-cycle pulse
      repeat (3) @(posedge sys_clk);
      {xosc_clk, lfosc_clk} <= 2'h0;
      ext_count_input <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    if (kind != 0) repeat (6) @(posedge sys_clk);
    rd(`ADDR_LOW, b);
    chk(b - a, e);
  endtask

  // Run a count up to a wrap point, check flag, interrupt and clearing
  task automatic ovf(input logic [15:0] v, input logic [1:0] s, input logic [7:0] m,
                     input logic [7:0] en);
    wr(`ADDR_MODE, 8'h07);
    wr(`ADDR_HIGH, v[15:8]);
    wr(`ADDR_LOW, v[7:0]);
    wr(`ADDR_CTRL, {6'h00, s});
    wr(`ADDR_IEN, en);
    chk({7'h00, irq}, 8'h00);
    wr(`ADDR_MODE, 8'h04);
    repeat (40) @(posedge sys_clk);
    rd(`ADDR_CTRL, a);
    chk(a & m, m);
    chk(a & 8'h03, {6'h00, s});
    chk({7'h00, irq}, 8'h01);
    wr(`ADDR_MODE, 8'h07);
    repeat (4) @(posedge sys_clk);
    rd(`ADDR_CTRL, a);
    chk(a & m, m);
    wr(`ADDR_CTRL, {6'h00, s});
    repeat (2) @(posedge sys_clk);
    rd(`ADDR_CTRL, a);
    chk(a & m, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the roughly 1300 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    req = '0;
    {ext_count_input, xosc_clk, lfosc_clk, t0_overflow, cpu_idle} = 5'h10;
    {global_irq_en, array_irq_en} = 2'h3;
    channel_event = 3'h0;
    channel_io_in = 3'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk({6'h00, watchdog_mode, irq}, 8'h02);
    // Locked while the watchdog runs: counter ignores writes, mode takes only a write that clears the watchdog bit
    wr(`ADDR_HIGH, 8'h55);
    wr(`ADDR_MODE, 8'h47);
    rd(`ADDR_LOW, a);
    rd(`ADDR_HIGH, b);
    chk(b, 8'h00);
    rd(`ADDR_MODE, a);
    chk(a, `MODE_RESET);
    rd(4'hf, a);
    chk(a, 8'h00);
    wr(`ADDR_MODE, 8'h07);
    rd(`ADDR_MODE, a);
    chk(a, 8'h07);
    chk({7'h00, watchdog_mode}, 8'h00);
    // Snapshot outlives a later write to the live high byte
    wr(`ADDR_HIGH, 8'h12);
    wr(`ADDR_LOW, 8'hfe);
    rd(`ADDR_LOW, a);
    chk(a, 8'hfe);
    wr(`ADDR_HIGH, 8'h34);
    rd(`ADDR_HIGH, a);
    chk(a, 8'h12);
    rd_pair(a, b);
    chk(b, 8'h34);
    chk(a, 8'hfe);
    // Every timebase code, read windows must not disturb counting
    cnt(8'h04, 0, 0, 8'd48);
    cnt(8'h01, 0, 0, 8'd12);
    cnt(8'h00, 0, 0, 8'd4);
    cnt(8'h07, 0, 0, 8'd0);
    cnt(8'h02, 1, 5, 8'd5);
    cnt(8'h03, 2, 4, 8'd4);
    cnt(8'h05, 3, 16, 8'd2);
    cnt(8'h06, 4, 16, 8'd2);
    cnt(8'h05, 4, 16, 8'd0);
    @(posedge sys_clk);
    cpu_idle <= 1'b1;
    cnt(8'h84, 0, 0, 8'd0);
    cnt(8'h04, 0, 0, 8'd48);
    @(posedge sys_clk);
    cpu_idle <= 1'b0;
    // Wrap points: full wrap and each intermediate bit
    ovf(16'hfff0, 2'h0, 8'h80, 8'h10);
    for (int s = 0; s < 4; s++)
      ovf(16'((1 << (8 + s)) - 16), 2'(s), 8'h40, 8'h08);
    rd(`ADDR_IEN, a);
    chk(a, 8'h08);
    // Channel flags set with enables off, then gated onto the request
    for (int i = 0; i < 3; i++) begin
      wr(`ADDR_IEN, 8'h00);
      wr(`ADDR_CTRL, 8'h00);
      @(posedge sys_clk);
      channel_event <= 3'(1 << i);
      @(posedge sys_clk);
      channel_event <= 3'h0;
      repeat (3) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      wr(`ADDR_IEN, 8'(1 << i));
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h01);
      if (i == 1) global_irq_en <= 1'b0;
      else array_irq_en <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      {global_irq_en, array_irq_en} <= 2'h3;
      wr(`ADDR_CTRL, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk({7'h00, irq}, 8'h00);
    end
    // Channel lines: synced input copy, outputs parked
    channel_io_in <= 3'h5;
    repeat (5) @(posedge sys_clk);
    chk({2'h0, channel_io_sync, channel_io_line}, 8'h28);
    chk({5'h00, channel_io_oe}, 8'h00);
    complete_run();
  end
endmodule // tb
